// ==== rtl/scmd_map.svh ====
/*
 * Command codes, status bit positions, slave address and timing
 * of the speech command front end.
 * Assumes nothing; definitions only.
 */
`ifndef SCMD_MAP_SVH
`define SCMD_MAP_SVH

`define SCMD_OP_PUP 8'h00
`define SCMD_MSK_PUP 8'hFC
`define SCMD_OP_POWER_DOWN_CMD 8'h20
`define SCMD_OP_FETCH 8'hB0
`define SCMD_OP_ANALOG_SETUP_CMD 8'h04
`define SCMD_OP_ANALOG_VOLUME_CMD 8'h08
`define SCMD_OP_PHRASE_SELECT_CMD 8'h30
`define SCMD_OP_PLAY 8'h40
`define SCMD_MSK_PH 8'hF2
`define SCMD_OP_SILENCE_INSERT_CMD 8'h70
`define SCMD_OP_CHANNEL_VOLUME_CMD 8'hA0
`define SCMD_MSK_CH 8'hFC
`define SCMD_MSK_ALL 8'hFF

`define SCMD_ST_BUSY2 6
`define SCMD_ST_BUSY1 5
`define SCMD_ST_ACC2 2
`define SCMD_ST_ACC1 0

`define SCMD_I2C_ADDR_LO 4'h5
`define SCMD_ANALOG_SETUP_CMD_RST 8'h00
`define SCMD_BANK_RST 2'h0

`define SCMD_CLK_MHZ 100
`define SCMD_PROC_NS 2000
`define SCMD_PROC_CYC ((`SCMD_PROC_NS * `SCMD_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/scmd_pkg.sv ====
/*
 * Types of the speech command front end.
 * Assumes scmd_map.svh for the numeric constants.
 */
package scmd_pkg;
    typedef enum logic [0:0] {
        PWR_DOWN = 1'b0,
        PWR_WAIT = 1'b1
    } scmd_pwr_type;

    typedef enum logic [1:0] {
        SI_IDLE = 2'b00,
        SI_ADDR = 2'b01,
        SI_WR = 2'b10,
        SI_RD = 2'b11
    } scmd_i2c_type;
endpackage : scmd_pkg

// ==== rtl/scmd_i2c_slave.sv ====
/*
 * Two-wire slave port: address match, write bytes, status read.
 * Assumes an open-drain bus resolved outside; scl and sda are slow
 * against mclk_i, so they are oversampled after two flip-flops.
 */
`timescale 1ns/1ps
`include "scmd_map.svh"

module scmd_i2c_slave (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] strap_i,
    input wire logic [7:0] rd_data_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic byte_v_o,
    output logic [7:0] byte_o,
    output logic first_o
);
    logic [4:0] m1, m2;
    logic scl_q, sda_q, scl, sda;
    logic rise, fall, start, stop;
    scmd_pkg::scmd_i2c_type st, next_st;
    logic ack, next_ack, drv, next_drv, bv, next_bv;
    logic first, next_first;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;

    assign scl = m2[4];
    assign sda = m2[3];
    assign rise = scl & ~scl_q;
    assign fall = ~scl & scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop = scl & scl_q & ~sda_q & sda;

    always_comb
    begin
        next_st = st;
        next_ack = ack;
        next_drv = drv;
        next_bv = 1'b0;
        next_first = first;
        next_cnt = cnt;
        next_sh = sh;
        if (start)
        begin
            next_st = scmd_pkg::SI_ADDR;
            next_cnt = 4'h0;
            next_ack = 1'b0;
            next_drv = 1'b0;
        end
        else if (stop)
        begin
            next_st = scmd_pkg::SI_IDLE;
            next_ack = 1'b0;
            next_drv = 1'b0;
        end
        else if (st != scmd_pkg::SI_IDLE)
        begin
            if (rise)
            begin
                // a not-acknowledge from the master ends the read
                if (ack && st == scmd_pkg::SI_RD && sda)
                    next_st = scmd_pkg::SI_IDLE;
                else if (!ack && st != scmd_pkg::SI_RD)
                begin
                    next_sh = {sh[6:0], sda};
                    next_cnt = cnt + 4'h1;
                end
            end
            else if (fall)
            begin
                if (ack)
                begin
                    next_ack = 1'b0;
                    next_drv = 1'b0;
                    next_cnt = 4'h0;
                    if (st == scmd_pkg::SI_ADDR)
                        next_st = sh[0] ? scmd_pkg::SI_RD
                                        : scmd_pkg::SI_WR;
                    if (st == scmd_pkg::SI_ADDR && !sh[0])
                        next_first = 1'b1;
                    else if (st == scmd_pkg::SI_WR)
                        next_first = 1'b0;
                    if (st == scmd_pkg::SI_RD ||
                        (st == scmd_pkg::SI_ADDR && sh[0]))
                    begin
                        next_sh = rd_data_i;
                        next_drv = ~rd_data_i[7];
                        next_cnt = 4'h1;
                    end
                end
                else if (st == scmd_pkg::SI_RD)
                begin
                    next_drv = ~sh[6];
                    next_sh = {sh[6:0], 1'b0};
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'h8)
                    begin
                        next_ack = 1'b1;
                        next_drv = 1'b0;
                        next_cnt = cnt;
                        next_sh = sh;
                    end
                end
                else if (cnt == 4'h8)
                begin
                    if (st == scmd_pkg::SI_WR)
                    begin
                        next_ack = 1'b1;
                        next_drv = 1'b1;
                        next_bv = 1'b1;
                    end
                    else if (sh[7:1] == {m2[2:0], `SCMD_I2C_ADDR_LO})
                    begin
                        next_ack = 1'b1;
                        next_drv = 1'b1;
                    end
                    else
                        next_st = scmd_pkg::SI_IDLE;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            m1 <= 5'h1F;
            m2 <= 5'h1F;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            st <= scmd_pkg::SI_IDLE;
            ack <= 1'b0;
            drv <= 1'b0;
            bv <= 1'b0;
            first <= 1'b0;
            cnt <= 4'h0;
            sh <= 8'h00;
        end
        else
        begin
            m1 <= {scl_i, sda_i, strap_i};
            m2 <= m1;
            scl_q <= scl;
            sda_q <= sda;
            st <= next_st;
            ack <= next_ack;
            drv <= next_drv;
            bv <= next_bv;
            first <= next_first;
            cnt <= next_cnt;
            sh <= next_sh;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = drv;
    assign byte_v_o = bv;
    assign byte_o = sh;
    assign first_o = first;
endmodule : scmd_i2c_slave

// ==== rtl/scmd_top.sv ====
/*
 * Command front end: three-wire serial port, two-wire slave port,
 * command decoder, power state and per-channel status flags.
 * Assumes the playback engine on mclk_i reports playing and standby
 * per channel; pins from the host are asynchronous.
 */
`timescale 1ns/1ps
`include "scmd_map.svh"

// Behaviour
// - chip select low enables serial port
// - serial bits shifted in MSB first
// - command runs on eighth sampling edge
// - polarity low: sample rising, drive falling
// - polarity high: sample falling, drive rising
// - status byte shifted out on serial_out
// - select high clears clock pulse count
// - status bits 6,5,2,0 carry channel flags
// - busy low while processing or playing
// - accept low while processing or standby
// - two-wire port is fast-mode slave only
// - address is straps then 0101
// - eighth address bit selects direction
// - whole bytes, each acknowledged
// - two-wire status refreshed by fetch only
// - commands are bytes; six take two
// - power-up leaves power-down, sets banks
// - power-down command enters power-down
// - analog setup second byte holds fields
// - play starts phrase on selected channel
module scmd_top #(
    parameter int PROC_CYC = `SCMD_PROC_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_shift_clock_i,
    input wire logic serial_in_i,
    input wire logic edge_polarity_select_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_strap_0_i,
    input wire logic addr_strap_1_i,
    input wire logic addr_strap_2_i,
    input wire logic [1:0] ch_playing_i,
    input wire logic [1:0] ch_standby_i,
    output logic ch1_busy_n_o,
    output logic ch2_busy_n_o,
    output logic ch1_accept_n_o,
    output logic ch2_accept_n_o,
    output logic powered_o,
    output logic [1:0] bank_count_sel_o,
    output logic [7:0] analog_setup_o,
    output logic play_start_o,
    output logic channel_sel_o,
    output logic [9:0] phrase_number_o
);
    // ****************************************
    // serial port
    // ****************************************
    logic [3:0] sy1, sy2;
    logic cs_n, sck, sin, pol, sck_q, cs_q;
    logic samp, shft, cs_fall, ser_v;
    logic [2:0] cnt, next_cnt;
    logic [6:0] ish, next_ish;
    logic [7:0] osh, next_osh, ser_byte, stat;

    assign {cs_n, sck, sin, pol} = sy2;
    assign cs_fall = cs_q & ~cs_n;
    assign samp = ~cs_n & (pol ? (~sck & sck_q)
                               : (sck & ~sck_q));
    assign shft = ~cs_n & (pol ? (sck & ~sck_q)
                               : (~sck & sck_q));
    assign ser_v = samp & (cnt == 3'h7);
    assign ser_byte = {ish, sin};

    always_comb
    begin
        next_cnt = cnt;
        next_ish = ish;
        next_osh = osh;
        if (cs_n)
            next_cnt = 3'h0;
        else if (samp)
        begin
            next_cnt = cnt + 3'h1;
            next_ish = {ish[5:0], sin};
        end
        // status only reloads on select fall; a held select repeats 0s
        if (cs_fall)
            next_osh = stat;
        else if (shft)
            next_osh = {osh[6:0], 1'b0};
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sy1 <= 4'hD;
            sy2 <= 4'hD;
            sck_q <= 1'b1;
            cs_q <= 1'b1;
            cnt <= 3'h0;
            ish <= 7'h00;
            osh <= 8'h00;
        end
        else
        begin
            sy1 <= {chip_select_n_i, serial_shift_clock_i,
                    serial_in_i, edge_polarity_select_i};
            sy2 <= sy1;
            sck_q <= sck;
            cs_q <= cs_n;
            cnt <= next_cnt;
            ish <= next_ish;
            osh <= next_osh;
        end
    end

    assign serial_out_o = osh[7];
    assign serial_out_oe_o = ~cs_n;

    // ****************************************
    // two-wire port
    // ****************************************
    logic i2c_v, i2c_first;
    logic [7:0] i2c_byte, i2c_stat, next_i2c_stat;

    scmd_i2c_slave u_i2c (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .strap_i({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i}),
        .rd_data_i(i2c_stat),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .byte_v_o(i2c_v),
        .byte_o(i2c_byte),
        .first_o(i2c_first)
    );

    // ****************************************
    // command decoder
    // ****************************************
    function automatic logic op_is(input logic [7:0] b,
                                   input logic [7:0] op,
                                   input logic [7:0] msk);
        op_is = (b & msk) == op;
    endfunction : op_is

    function automatic logic two_byte(input logic [7:0] b);
        two_byte = op_is(b, `SCMD_OP_ANALOG_SETUP_CMD, `SCMD_MSK_ALL) |
                   op_is(b, `SCMD_OP_ANALOG_VOLUME_CMD, `SCMD_MSK_ALL) |
                   op_is(b, `SCMD_OP_PHRASE_SELECT_CMD, `SCMD_MSK_PH) |
                   op_is(b, `SCMD_OP_PLAY, `SCMD_MSK_PH) |
                   op_is(b, `SCMD_OP_SILENCE_INSERT_CMD, `SCMD_MSK_CH) |
                   op_is(b, `SCMD_OP_CHANNEL_VOLUME_CMD, `SCMD_MSK_CH);
    endfunction : two_byte

    localparam logic [11:0] PROC_LD = 12'(PROC_CYC);
    scmd_pkg::scmd_pwr_type pwr, next_pwr;
    logic byte_v, new_cmd, pend, next_pend, busy;
    logic play, next_play, ch, next_ch;
    logic [7:0] cmd, first_b, next_first_b, analog_setup_cmd, next_analog_setup_cmd;
    logic [1:0] bank, next_bank, busy_n, acc_n, next_busy_n, next_acc_n;
    logic [9:0] phr, next_phr;
    logic [11:0] proc_cnt, next_proc;

    // serial wins when both ports finish a byte in one cycle
    assign byte_v = ser_v | i2c_v;
    assign cmd = ser_v ? ser_byte : i2c_byte;
    assign new_cmd = ~pend | (~ser_v & i2c_first);
    assign busy = proc_cnt != 12'h000;

    always_comb
    begin
        next_pwr = pwr;
        next_pend = pend;
        next_first_b = first_b;
        next_analog_setup_cmd = analog_setup_cmd;
        next_bank = bank;
        next_play = 1'b0;
        next_ch = ch;
        next_phr = phr;
        next_i2c_stat = i2c_stat;
        next_proc = busy ? proc_cnt - 12'h001 : 12'h000;
        if (byte_v)
        begin
            next_proc = PROC_LD;
            next_pend = 1'b0;
            if (!new_cmd)
            begin
                if (op_is(first_b, `SCMD_OP_ANALOG_SETUP_CMD, `SCMD_MSK_ALL))
                    next_analog_setup_cmd = cmd;
                if (op_is(first_b, `SCMD_OP_PLAY, `SCMD_MSK_PH) &&
                    pwr == scmd_pkg::PWR_WAIT)
                begin
                    next_play = 1'b1;
                    next_ch = first_b[0];
                    next_phr = {first_b[3:2], cmd};
                end
            end
            else if (two_byte(cmd))
            begin
                next_pend = 1'b1;
                next_first_b = cmd;
            end
            else if (op_is(cmd, `SCMD_OP_PUP, `SCMD_MSK_PUP) &&
                     pwr == scmd_pkg::PWR_DOWN)
            begin
                next_pwr = scmd_pkg::PWR_WAIT;
                next_bank = cmd[1:0];
            end
            else if (op_is(cmd, `SCMD_OP_POWER_DOWN_CMD, `SCMD_MSK_ALL) &&
                     pwr == scmd_pkg::PWR_WAIT)
                next_pwr = scmd_pkg::PWR_DOWN;
            else if (op_is(cmd, `SCMD_OP_FETCH, `SCMD_MSK_ALL) &&
                     !ser_v)
                next_i2c_stat = stat;
        end
        next_busy_n = ~({2{busy}} | ch_playing_i);
        next_acc_n = ~({2{busy}} | ch_standby_i);
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pwr <= scmd_pkg::PWR_DOWN;
            pend <= 1'b0;
            first_b <= 8'h00;
            analog_setup_cmd <= `SCMD_ANALOG_SETUP_CMD_RST;
            bank <= `SCMD_BANK_RST;
            play <= 1'b0;
            ch <= 1'b0;
            phr <= 10'h000;
            i2c_stat <= 8'h00;
            proc_cnt <= 12'h000;
            busy_n <= 2'h3;
            acc_n <= 2'h3;
        end
        else
        begin
            pwr <= next_pwr;
            pend <= next_pend;
            first_b <= next_first_b;
            analog_setup_cmd <= next_analog_setup_cmd;
            bank <= next_bank;
            play <= next_play;
            ch <= next_ch;
            phr <= next_phr;
            i2c_stat <= next_i2c_stat;
            proc_cnt <= next_proc;
            busy_n <= next_busy_n;
            acc_n <= next_acc_n;
        end
    end

    always_comb
    begin
        stat = 8'h00;
        stat[`SCMD_ST_BUSY2] = busy_n[1];
        stat[`SCMD_ST_BUSY1] = busy_n[0];
        stat[`SCMD_ST_ACC2] = acc_n[1];
        stat[`SCMD_ST_ACC1] = acc_n[0];
    end

    assign ch1_busy_n_o = busy_n[0];
    assign ch2_busy_n_o = busy_n[1];
    assign ch1_accept_n_o = acc_n[0];
    assign ch2_accept_n_o = acc_n[1];
    assign powered_o = pwr == scmd_pkg::PWR_WAIT;
    assign bank_count_sel_o = bank;
    assign analog_setup_o = analog_setup_cmd;
    assign play_start_o = play;
    assign channel_sel_o = ch;
    assign phrase_number_o = phr;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_select_gates_out: assert property (
        serial_out_oe_o == !$past(chip_select_n_i, 2))
        else $error("serial out enable wrong");
    a_msb_first_in: assert property (
        samp ##1 !cs_n |-> ish[0] == $past(sin))
        else $error("serial bit order wrong");
    a_byte_on_eighth: assert property (
        ser_v |=> cnt == 3'h0 && proc_cnt == PROC_LD)
        else $error("byte not executed on eighth edge");
    a_count_clears: assert property (
        cs_n |=> cnt == 3'h0) else $error("pulse count not cleared");
    a_out_shifts: assert property (
        shft && !cs_fall |=> osh[7] == $past(osh[6]))
        else $error("status not shifted");
    a_busy_playing: assert property (
        ch_playing_i[1] |=> !ch2_busy_n_o)
        else $error("busy not low while playing");
    a_accept_idle: assert property (
        !busy && ch_standby_i == 2'h0 |=> ch1_accept_n_o && ch2_accept_n_o)
        else $error("accept low while idle");
    a_spare_bits_zero: assert property (
        cs_fall |=> (osh & 8'h9A) == 8'h00)
        else $error("spare status bits set");
    a_fetch_only: assert property (
        !$stable(i2c_stat) |-> $past(byte_v) && !$past(ser_v))
        else $error("two-wire status moved without fetch");
    a_power_down: assert property (
        byte_v && new_cmd && cmd == `SCMD_OP_POWER_DOWN_CMD |=> !powered_o)
        else $error("power-down not taken");

    c_serial_byte: cover property (ser_v);
    c_i2c_byte: cover property (i2c_v ##[1:1000] i2c_v);
    c_power_up: cover property (!powered_o ##1 powered_o);
    c_play: cover property (play_start_o);
endmodule : scmd_top

// ==== testbench/scmd_host.sv ====
/*
 * Serial host model for the command front end: frames bytes on the
 * three-wire port and samples the returned status bits.
 * Assumes the bench calls xfer between frames; mclk_i is 100 MHz.
 */
`timescale 1ns/1ps

module scmd_host (
    input wire logic mclk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic pol_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        pol_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick

    // sel is the select level; hold keeps select low after the frame
    task automatic xfer(input logic [7:0] cmd, input int n,
                        input logic sel, input logic hold,
                        input logic pol, output logic [7:0] st);
        st = 8'h00;
        if (cs_n_o)
        begin
            // idle level moves only with select high
            pol_o = pol;
            sck_o = pol;
            tick(4);
        end
        cs_n_o = sel;
        si_o = cmd[7];
        tick(6);
        for (int i = 7; i >= 8 - n; i--)
        begin
            st[i] = so_i;
            sck_o = ~pol;
            tick(4);
            sck_o = pol;
            si_o = (i > 0) ? cmd[i - 1] : ~cmd[0];
            tick(4);
        end
        if (!hold)
        begin
            cs_n_o = 1'b1;
            // released data line must not look held
            si_o = ~si_o;
        end
        tick(4);
    endtask : xfer
endmodule : scmd_host

// ==== testbench/tb.sv ====
/*
 * Self-checking bench of scmd_top: serial host model, a two-wire
 * master in tasks, random channel flags and command fields.
 * Assumes a 100 MHz clock and PROC_CYC shortened to 40.
 */
`timescale 1ns/1ps

module tb;
    localparam int PROC = 40;
    logic mclk, rst, cs_n, sck, si, pol, so, so_oe;
    logic scl, sda_drv, sda, sda_o, sda_oe;
    logic [2:0] strap;
    logic [1:0] pl, sb, bk, bank;
    logic b1, b2, a1, a2, powered, play_start, ch_sel, k, kd;
    logic [7:0] aset, st, r, ax, aw;
    logic [9:0] phrase, ph;
    int failures, check_count, cyc, plays, p0;

    // open drain with pull-up
    assign sda = sda_drv & (~sda_oe | sda_o);

    scmd_top #(.PROC_CYC(PROC)) i_dut (
        .mclk_i(mclk), .rst_i(rst), .chip_select_n_i(cs_n),
        .serial_shift_clock_i(sck), .serial_in_i(si),
        .edge_polarity_select_i(pol), .serial_out_o(so),
        .serial_out_oe_o(so_oe), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_0_i(strap[0]),
        .addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[2]),
        .ch_playing_i(pl), .ch_standby_i(sb), .ch1_busy_n_o(b1),
        .ch2_busy_n_o(b2), .ch1_accept_n_o(a1), .ch2_accept_n_o(a2),
        .powered_o(powered), .bank_count_sel_o(bank),
        .analog_setup_o(aset), .play_start_o(play_start),
        .channel_sel_o(ch_sel), .phrase_number_o(phrase)
    );

    scmd_host i_host (.mclk_i(mclk), .so_i(so), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si), .pol_o(pol));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (play_start === 1'b1)
            plays++;
        if (cyc == 60000)
        begin
            failures++;
            results();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                       input string m);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] exp_st(logic [1:0] p, logic [1:0] s);
        return {1'b0, ~p, 2'b00, ~s[1], 1'b0, ~s[0]};
    endfunction : exp_st

    task automatic send(input logic [7:0] c, output logic [7:0] s);
        i_host.xfer(c, 8, 1'b0, 1'b0, 1'($urandom), s);
        chk({b2, b1, a2, a1}, 4'h0, "flags while processing");
        tick(PROC + 20);
        chk({b2, b1, a2, a1}, {~pl, ~sb}, "flags at rest");
    endtask : send

    task automatic ibit(input logic b, output logic v);
        sda_drv = b;
        tick(65);
        scl = 1'b1;
        tick(65);
        v = sda;
        tick(65);
        scl = 1'b0;
        tick(65);
    endtask : ibit

    task automatic ibyte(input logic [7:0] b, output logic [7:0] v,
                         output logic a);
        for (int i = 7; i >= 0; i--)
            ibit(b[i], v[i]);
        ibit(1'b1, a);
    endtask : ibyte

    // start, address byte, one data byte, stop
    task automatic iop(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] v, output logic ka,
                       output logic kb);
        // start: data falls while the clock is high
        sda_drv = 1'b1;
        tick(65);
        scl = 1'b1;
        tick(65);
        sda_drv = 1'b0;
        tick(65);
        scl = 1'b0;
        tick(65);
        ibyte(a, v, ka);
        ibyte(d, v, kb);
        sda_drv = 1'b0;
        tick(65);
        scl = 1'b1;
        tick(65);
        sda_drv = 1'b1;
        tick(130);
    endtask : iop

    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        scl = 1'b1;
        sda_drv = 1'b1;
        pl = 2'b00;
        sb = 2'b00;
        strap = 3'($urandom(28688));
        tick(3);
        rst = 1'b0;
        tick(1);
        chk({b2, b1, a2, a1, powered, so_oe, sda_oe, sda_o}, 8'hF0, "reset");
        chk({bank, aset}, 10'h000, "reset fields");
        i_host.xfer(8'h03, 8, 1'b1, 1'b0, 1'b0, st);
        tick(PROC);
        chk(powered, 1'b0, "deselected frame");
        i_host.xfer(8'h00, 3, 1'b0, 1'b0, 1'b1, st);
        bk = 2'($urandom);
        send({6'h00, bk}, st);
        chk({powered, bank}, {1'b1, bk}, "power up");
        send(8'h20, st);
        chk(powered, 1'b0, "power down");
        p0 = plays;
        send(8'h41, st);
        send(8'h55, st);
        send(8'h04, st);
        send(8'h5A, st);
        chk({2'(plays - p0), aset}, 10'h05A, "play ignored down");
        send(8'h01, st);
        ax = 8'($urandom);
        send(8'h04, st);
        send(ax, st);
        chk(aset, ax, "analog setup");
        foreach (aw[i])
            if (i < 4)
            begin
                send(i == 0 ? 8'h08 : i == 1 ? 8'h35 : i == 2 ? 8'h71
                     : 8'hA2, st);
                send(8'h20, st);
                chk({powered, aset}, {1'b1, ax}, "second byte");
            end
        for (int c = 0; c < 2; c++)
        begin
            ph = 10'($urandom);
            p0 = plays;
            send({4'h4, ph[9:8], 1'b0, 1'(c)}, st);
            send(ph[7:0], st);
            chk({9'(plays - p0), ch_sel}, 10'(2 + c), "play pulse");
            chk(phrase, ph, "phrase");
        end
        for (int n = 0; n < 12; n++)
        begin
            pl = 2'($urandom);
            sb = (n == 0) ? 2'b01 : 2'($urandom);
            tick(4);
            send(8'hB0, st);
            chk(st, exp_st(pl, sb), "serial status");
        end
        i_host.xfer(8'hB0, 8, 1'b0, 1'b1, 1'b0, st);
        i_host.xfer(8'h20, 8, 1'b0, 1'b0, 1'b0, st);
        tick(PROC + 20);
        chk({st, powered}, 9'h000, "select held low");
        aw = {strap, 4'h5, 1'b0};
        iop(aw, {6'h00, bk ^ 2'b11}, r, k, kd);
        tick(PROC + 20);
        chk({k, kd}, 2'b00, "write acks");
        chk({powered, bank}, {1'b1, bk ^ 2'b11}, "two-wire up");
        iop(aw ^ 8'h10, 8'h20, r, k, kd);
        tick(PROC + 20);
        chk({k, powered}, 2'b11, "foreign address");
        pl = 2'b01;
        sb = 2'b10;
        iop(aw, 8'hB0, r, k, kd);
        tick(PROC + 20);
        iop(aw | 8'h01, 8'hFF, r, k, kd);
        ax = exp_st(2'b01, 2'b10);
        chk({k, r}, {1'b0, ax}, "two-wire status");
        // live flags move, the snapshot must not
        pl = 2'b10;
        sb = 2'b01;
        tick(PROC + 20);
        iop(aw | 8'h01, 8'hFF, r, k, kd);
        chk(r, ax, "status not refreshed");
        results();
    end
endmodule : tb
